// ### logic/tpc_pkg.sv
package tpc_pkg;

  localparam int unsigned  TPC_CLK_HZ       = 200_000_000;
  localparam int unsigned  TPC_SYNC_MIN_NS  = 20;
  localparam int unsigned  TPC_SYNC_MIN_CYC = (TPC_SYNC_MIN_NS * (TPC_CLK_HZ / 1_000_000) + 999) / 1000;

  // register offsets (byte address, one word each)
  localparam logic [7:0] TPC_OFF_CTRL    = 8'h00;
  localparam logic [7:0] TPC_OFF_MOD     = 8'h04;
  localparam logic [7:0] TPC_OFF_CNT     = 8'h08;
  localparam logic [7:0] TPC_OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] TPC_OFF_GATE    = 8'h10;
  localparam logic [7:0] TPC_OFF_CH_BASE = 8'h20;
  localparam logic [7:0] TPC_OFF_CH_STEP = 8'h08;
  localparam logic [7:0] TPC_OFF_CH_VAL  = 8'h04;

  // control register fields
  localparam int unsigned TPC_CTRL_PS_LSB  = 0;
  localparam int unsigned TPC_CTRL_CLK_LSB = 3;
  localparam int unsigned TPC_CTRL_CENTER_ALIGNED_PULSE_MODE    = 5;
  localparam int unsigned TPC_CTRL_TOIE    = 6;
  localparam int unsigned TPC_CTRL_ROUTE   = 7;
  localparam int unsigned TPC_CTRL_UPDN    = 8;
  localparam int unsigned TPC_GATE_BIT     = 0;
  localparam logic [1:0]  TPC_GATE_RST     = 2'h3;

  // channel control fields
  localparam int unsigned TPC_CH_EL_LSB = 0;
  localparam int unsigned TPC_CH_MS_LSB = 2;
  localparam int unsigned TPC_CH_IE     = 4;

  localparam logic [15:0] TPC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TPC_CNT_FULL = 16'hffff;

  typedef enum logic [1:0] {
    TPC_CLK_NONE  = 2'b00,
    TPC_CLK_BUS   = 2'b01,
    TPC_CLK_FIXED = 2'b10,
    TPC_CLK_EXT   = 2'b11
  } tpc_clk_sel_type;

  typedef enum logic [1:0] {
    TPC_MS_CAPTURE = 2'b00,
    TPC_MS_COMPARE = 2'b01,
    TPC_MS_PWM     = 2'b10,
    TPC_MS_PWM2    = 2'b11
  } tpc_ch_mode_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tpc_bus_req_type;

endpackage : tpc_pkg

// ### logic/tpc_timer.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - comparator route feeds channel zero capture
// - routing disconnects channel zero pin externally
// - gate bits set on reset, clearing bit zero stops
// - power-of-two prescaler on any source
// - count clock from bus, fixed, external
// - shared 16-bit counter, free/modulus, up/updown
// - per-channel interrupt plus overflow interrupt
// - centre mode disables other channel functions
// - debug mode holds all counting
// - stop halts timer, wait keeps running
// - capture copies counter, sets flag on edge
// - compare match sets flag, applies pin action
// - edge pwm period modulo plus one
// - edge pwm interrupts at period and duty
// - centre pwm counts up then down
// - centre pwm active down-match, inactive up-match
// - modulo zero or all-ones runs free
// - counter reads do not disturb counting
// - any counter write resets counter
// - pin and external clock inputs synchronised, pulses four bus clocks
module tpc_timer
  import tpc_pkg::*;
#(
  parameter int unsigned NUM_CH = 8
) (
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire tpc_bus_req_type   bus_req_in,
  output logic        [31:0]     rdata_out,
  input  wire logic              fixed_tick_in,
  input  wire logic              ext_clk_pin_in,
  input  wire logic              cmp_out_in,
  input  wire logic              debug_hold_in,
  input  wire logic              stop_mode_in,
  input  wire logic [NUM_CH-1:0] ch_pin_in,
  output logic      [NUM_CH-1:0] ch_pin_out,
  output logic      [NUM_CH-1:0] ch_pin_oe_out,
  output logic      [NUM_CH-1:0] ch_irq_out,
  output logic                   ovf_irq_out
);

  // refused at elaboration: flag word and channel map hold at most eight
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
    $error("NUM_CH must be 1 to 8");
  end

  logic [8:0]            ctrl_ff;
  logic [15:0]           mod_ff;
  logic [15:0]           cnt_ff;
  logic                  down_ff;
  logic [1:0]            gate_ff;
  logic [6:0]            pre_ff;
  logic                  ovf_ff;
  logic [NUM_CH-1:0]     chf_ff;
  logic [4:0]            chc_ff  [NUM_CH];
  logic [15:0]           chv_ff  [NUM_CH];
  logic [NUM_CH-1:0]     pin_ff;
  logic [NUM_CH-1:0]     oe_ff;
  logic [NUM_CH-1:0]     s1_ff, s2_ff, s3_ff;
  logic [2:0]            ext_ff;
  logic                  cmp_ff;
  logic [31:0]           rdata_ff;

  // register address decode, used by both the write and read paths
  function automatic logic is_ch(input logic [7:0] a, input int unsigned n, input logic [7:0] sub);
    is_ch = (a == 8'(TPC_OFF_CH_BASE + n * TPC_OFF_CH_STEP + sub));
  endfunction : is_ch

  wire logic wr_ctrl = bus_req_in.wr && bus_req_in.addr == TPC_OFF_CTRL;
  wire logic wr_mod  = bus_req_in.wr && bus_req_in.addr == TPC_OFF_MOD;
  wire logic wr_cnt  = bus_req_in.wr && bus_req_in.addr == TPC_OFF_CNT;
  wire logic wr_flg  = bus_req_in.wr && bus_req_in.addr == TPC_OFF_FLAGS;
  wire logic wr_gate = bus_req_in.wr && bus_req_in.addr == TPC_OFF_GATE;

  wire logic            center_aligned_pulse_mode   = ctrl_ff[TPC_CTRL_CENTER_ALIGNED_PULSE_MODE];
  wire logic            route  = ctrl_ff[TPC_CTRL_ROUTE];
  wire tpc_clk_sel_type clksel = tpc_clk_sel_type'(ctrl_ff[TPC_CTRL_CLK_LSB +: 2]);
  wire logic [2:0]      ps     = ctrl_ff[TPC_CTRL_PS_LSB +: 3];
  // the whole timer shares gate bit zero; bit one is only stored and read back
  wire logic            run    = gate_ff[TPC_GATE_BIT] && !stop_mode_in;

  // external clock is synchronised, so it must be slow against mclk
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_ff <= 3'h0;
    end else begin
      ext_ff <= {ext_ff[1:0], ext_clk_pin_in};
    end
  end

  logic src_tick;
  always_comb begin
    case (clksel)
      TPC_CLK_BUS:   src_tick = 1'b1;
      TPC_CLK_FIXED: src_tick = fixed_tick_in;
      TPC_CLK_EXT:   src_tick = ext_ff[1] && !ext_ff[2];
      default:       src_tick = 1'b0;
    endcase
  end

  // prescaler: tick when the low ps bits all wrap
  wire logic src_ok  = src_tick && run && !debug_hold_in;
  wire logic [6:0] pmask = 7'((8'h01 << ps) - 8'h01);
  wire logic cnt_tick = src_ok && ((pre_ff & pmask) == pmask);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pre_ff <= 7'h00;
    end else if (wr_cnt) begin
      pre_ff <= 7'h00;
    end else if (src_ok) begin
      pre_ff <= pre_ff + 7'h01;
    end
  end

  wire logic        mod_free = (mod_ff == TPC_CNT_ZERO) || (mod_ff == TPC_CNT_FULL);
  wire logic [15:0] top      = mod_free ? TPC_CNT_FULL : mod_ff;
  wire logic        updn     = center_aligned_pulse_mode || ctrl_ff[TPC_CTRL_UPDN];
  wire logic        wrap     = cnt_tick && !updn && cnt_ff == top;
  wire logic        bottom   = cnt_tick && updn && down_ff && cnt_ff == 16'h0001;
  wire logic        ovf_ev   = wrap || bottom;

  // counter; reads never touch it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff  <= TPC_CNT_ZERO;
      down_ff <= 1'b0;
    end else if (wr_cnt) begin
      cnt_ff  <= TPC_CNT_ZERO;
      down_ff <= 1'b0;
    end else if (cnt_tick) begin
      if (!updn) begin
        cnt_ff <= wrap ? TPC_CNT_ZERO : cnt_ff + 16'h0001;
      end else if (!down_ff) begin
        if (cnt_ff >= top) begin
          down_ff <= 1'b1;
          cnt_ff  <= cnt_ff - 16'h0001;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end else begin
        if (cnt_ff <= 16'h0001) begin
          down_ff <= 1'b0;
        end
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= 9'h000;
      mod_ff  <= TPC_CNT_ZERO;
      gate_ff <= TPC_GATE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= bus_req_in.wdata[8:0];
      end
      if (wr_mod) begin
        mod_ff <= bus_req_in.wdata[15:0];
      end
      if (wr_gate) begin
        gate_ff <= bus_req_in.wdata[1:0];
      end
    end
  end

  // overflow flag: set wins over a software clear
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovf_ff <= 1'b0;
    end else if (ovf_ev) begin
      ovf_ff <= 1'b1;
    end else if (wr_flg && bus_req_in.wdata[NUM_CH]) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      cmp_ff <= 1'b0;
    end else begin
      s1_ff  <= ch_pin_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      // previous comparator level, else a routed edge could never be seen
      cmp_ff <= cmp_out_in;
    end
  end

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    wire logic [1:0]      el   = chc_ff[n][TPC_CH_EL_LSB +: 2];
    wire tpc_ch_mode_type ms   = tpc_ch_mode_type'(chc_ff[n][TPC_CH_MS_LSB +: 2]);
    wire logic            rte  = (n == 0) && route;
    // comparator output is already on mclk, so it skips the pin synchroniser
    wire logic            cur  = rte ? cmp_out_in : s2_ff[n];
    wire logic            prv  = rte ? cmp_ff : s3_ff[n];
    wire logic            rise = cur && !prv;
    wire logic            fall = !cur && prv;
    wire logic            cap  = !center_aligned_pulse_mode && ms == TPC_MS_CAPTURE &&
                                 ((el[0] && rise) || (el[1] && fall));
    wire logic            match = cnt_tick && cnt_ff == chv_ff[n];
    wire logic            edge_aligned_pulse_mode  = !center_aligned_pulse_mode && ms[1];
    wire logic            cmpm  = !center_aligned_pulse_mode && ms == TPC_MS_COMPARE;
    wire logic            ev    = cap || (match && el != 2'b00 && (cmpm || edge_aligned_pulse_mode || center_aligned_pulse_mode))
                                  || (match && cmpm);

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        chc_ff[n] <= 5'h00;
        chv_ff[n] <= TPC_CNT_ZERO;
      end else begin
        if (bus_req_in.wr && is_ch(bus_req_in.addr, n, 8'h00)) begin
          chc_ff[n] <= bus_req_in.wdata[4:0];
        end
        if (cap) begin
          chv_ff[n] <= cnt_ff;
        end else if (bus_req_in.wr && is_ch(bus_req_in.addr, n, TPC_OFF_CH_VAL)) begin
          chv_ff[n] <= bus_req_in.wdata[15:0];
        end
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        chf_ff[n] <= 1'b0;
      end else begin
        if (ev || (edge_aligned_pulse_mode && wrap)) begin
          chf_ff[n] <= 1'b1;
        end else if (wr_flg && bus_req_in.wdata[n]) begin
          chf_ff[n] <= 1'b0;
        end
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        pin_ff[n] <= 1'b0;
        oe_ff[n]  <= 1'b0;
      end else begin
        oe_ff[n] <= !rte && el != 2'b00 && (center_aligned_pulse_mode || ms != TPC_MS_CAPTURE);
        if (center_aligned_pulse_mode) begin
          if (match && !down_ff) begin
            pin_ff[n] <= el[0];
          end else if (match && down_ff) begin
            pin_ff[n] <= !el[0];
          end
        end else if (edge_aligned_pulse_mode) begin
          if (match) begin
            pin_ff[n] <= el[0];
          end else if (wrap || (cnt_tick && cnt_ff == TPC_CNT_ZERO && !wrap)) begin
            if (cnt_ff == TPC_CNT_ZERO || wrap) pin_ff[n] <= !el[0];
          end
        end else if (cmpm && match) begin
          case (el)
            2'b01:   pin_ff[n] <= !pin_ff[n];
            2'b10:   pin_ff[n] <= 1'b0;
            2'b11:   pin_ff[n] <= 1'b1;
            default: pin_ff[n] <= pin_ff[n];
          endcase
        end
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        ch_irq_out[n] <= 1'b0;
      end else begin
        ch_irq_out[n] <= chf_ff[n] && chc_ff[n][TPC_CH_IE];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovf_irq_out <= 1'b0;
    end else begin
      ovf_irq_out <= ovf_ff && ctrl_ff[TPC_CTRL_TOIE];
    end
  end

  logic [31:0] rsel;
  always_comb begin
    rsel = 32'h0000_0000;
    case (bus_req_in.addr)
      TPC_OFF_CTRL:  rsel = {23'h0, ctrl_ff};
      TPC_OFF_MOD:   rsel = {16'h0, mod_ff};
      TPC_OFF_CNT:   rsel = {16'h0, cnt_ff};
      TPC_OFF_FLAGS: rsel = 32'({down_ff, ovf_ff, chf_ff});
      TPC_OFF_GATE:  rsel = {30'h0, gate_ff};
      default: begin
        for (int unsigned n = 0; n < NUM_CH; n++) begin
          if (is_ch(bus_req_in.addr, n, 8'h00)) rsel = {27'h0, chc_ff[n]};
          if (is_ch(bus_req_in.addr, n, TPC_OFF_CH_VAL)) rsel = {16'h0, chv_ff[n]};
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= bus_req_in.rd ? rsel : 32'h0000_0000;
    end
  end

  assign rdata_out     = rdata_ff;
  assign ch_pin_out    = pin_ff;
  assign ch_pin_oe_out = oe_ff;

endmodule : tpc_timer

// ### verification/tpc_timer_sva.sv
`timescale 1ns/1ps
module tpc_chk
  import tpc_pkg::*;
#(
  parameter int unsigned NUM_CH = 8
) (
  input wire logic              mclk_in,
  input wire logic              sys_rst_in,
  input wire tpc_bus_req_type   bus_req_in,
  input wire logic [31:0]       rdata_out,
  input wire logic              fixed_tick_in,
  input wire logic              ext_clk_pin_in,
  input wire logic              cmp_out_in,
  input wire logic              debug_hold_in,
  input wire logic              stop_mode_in,
  input wire logic [NUM_CH-1:0] ch_pin_in,
  input wire logic [NUM_CH-1:0] ch_pin_out,
  input wire logic [NUM_CH-1:0] ch_pin_oe_out,
  input wire logic [NUM_CH-1:0] ch_irq_out,
  input wire logic              ovf_irq_out
);
  logic [8:0] ctrl_ff;
  logic [1:0] gate_ff;
  logic       ie0_ff;
  logic [1:0] age_ff;
  logic       quiet;
  logic       wr;
  // shadows follow bus writes, so a broken readback cannot hide a fault
  assign wr = bus_req_in.wr;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= 9'h000;
      gate_ff <= TPC_GATE_RST;
      ie0_ff  <= 1'b0;
      age_ff  <= 2'h0;
    end else begin
      age_ff <= {age_ff[0], wr};
      if (wr && bus_req_in.addr == TPC_OFF_CTRL) ctrl_ff <= bus_req_in.wdata[8:0];
      if (wr && bus_req_in.addr == TPC_OFF_GATE) gate_ff <= bus_req_in.wdata[1:0];
      if (wr && bus_req_in.addr == TPC_OFF_CH_BASE) ie0_ff <= bus_req_in.wdata[TPC_CH_IE];
    end
  end
  // writes may legally move pins, so holds are judged only in quiet spells
  assign quiet = !wr && age_ff == 2'h0;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  route_oe_a: assert property (ctrl_ff[7] && $past(ctrl_ff[7]) |-> !ch_pin_oe_out[0])
    else $error("routed pin driven");
  ovf_ie_a: assert property (ovf_irq_out |-> $past(ctrl_ff[6]))
    else $error("overflow request without enable");
  ch_ie_a: assert property (ch_irq_out[0] |-> $past(ie0_ff))
    else $error("channel request without enable");
  dbg_hold_a: assert property (debug_hold_in [*4] ##0 quiet |->
    $stable(ch_pin_out) && !$rose(ovf_irq_out)) else $error("moved in debug hold");
  stop_hold_a: assert property (stop_mode_in [*4] ##0 quiet |->
    $stable(ch_pin_out) && !$rose(ovf_irq_out)) else $error("moved in stop");
  gate_hold_a: assert property (!gate_ff[0] [*4] ##0 quiet |->
    $stable(ch_pin_out) && !$rose(ovf_irq_out)) else $error("moved while gated");
  gate_rd_a: assert property ($past(bus_req_in.rd) && $past(bus_req_in.addr) == TPC_OFF_GATE
    |-> rdata_out[1:0] == $past(gate_ff)) else $error("gate readback wrong");
  rst_quiet_a: assert property ($past(sys_rst_in) |-> ch_irq_out == '0 && !ovf_irq_out)
    else $error("request right after reset");
endmodule : tpc_chk
bind tpc_timer tpc_chk #(.NUM_CH(NUM_CH)) chk_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .bus_req_in(bus_req_in), .rdata_out(rdata_out), .fixed_tick_in(fixed_tick_in),
  .ext_clk_pin_in(ext_clk_pin_in), .cmp_out_in(cmp_out_in), .debug_hold_in(debug_hold_in),
  .stop_mode_in(stop_mode_in), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
  .ch_pin_oe_out(ch_pin_oe_out), .ch_irq_out(ch_irq_out), .ovf_irq_out(ovf_irq_out));

// ### verification/tpc_pin_model.sv
`timescale 1ns/1ps
module tpc_pin_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] dut_pin_in,
  input  wire logic [7:0] dut_oe_in,
  output logic      [7:0] pin_out,
  output logic            ext_clk_out,
  output logic            cmp_out
);
  logic [7:0] drv_ff;
  logic [1:0] div_ff;
  initial begin
    drv_ff = 8'h00;
    div_ff = 2'h0;
    ext_clk_out = 1'b0;
    cmp_out = 1'b0;
  end
  // the wire follows the timer while it drives, else this model
  assign pin_out = (dut_oe_in & dut_pin_in) | (~dut_oe_in & drv_ff);
  // eight bus clocks a period: safely under the quarter-rate ceiling
  always @(posedge mclk_in) begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3) ext_clk_out <= ~ext_clk_out;
  end
  task automatic pulse_pin(input int n);
    drv_ff[n] <= 1'b1;
    repeat (6) @(posedge mclk_in);
    drv_ff[n] <= 1'b0;
  endtask : pulse_pin
  task automatic pulse_cmp();
    cmp_out <= 1'b1;
    repeat (6) @(posedge mclk_in);
    cmp_out <= 1'b0;
  endtask : pulse_cmp
endmodule : tpc_pin_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import tpc_pkg::*;
  logic            mclk_in;
  logic            sys_rst_in;
  tpc_bus_req_type req;
  logic [31:0]     rdata;
  logic [31:0]     rv;
  logic [15:0]     a;
  logic [7:0]      pins;
  logic [7:0]      pout;
  logic [7:0]      poe;
  logic [7:0]      irq;
  logic            ovf;
  logic            tick;
  logic [1:0]      tcnt;
  logic            ext;
  logic            cmp;
  logic            dbg;
  logic            stp;
  int              failures;
  int              n_checks;
  int              cycles;
  tpc_timer #(.NUM_CH(8)) dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_req_in(req),
    .rdata_out(rdata), .fixed_tick_in(tick), .ext_clk_pin_in(ext), .cmp_out_in(cmp),
    .debug_hold_in(dbg), .stop_mode_in(stp), .ch_pin_in(pins), .ch_pin_out(pout),
    .ch_pin_oe_out(poe), .ch_irq_out(irq), .ovf_irq_out(ovf));
  tpc_pin_model pm_u (.mclk_in(mclk_in), .dut_pin_in(pout), .dut_oe_in(poe), .pin_out(pins),
    .ext_clk_out(ext), .cmp_out(cmp));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // strobes stay up until the next task overwrites them or idle drops them
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req.rd <= 1'b0;
    #1;
    rv = rdata; // read data stand only in this cycle
    @(posedge mclk_in);
  endtask : rd
  task automatic idle(input int n);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (n) @(posedge mclk_in);
  endtask : idle
  task automatic gap_chk(input int g, input logic [15:0] e, input string nm);
    rd(TPC_OFF_CNT);
    a = rv[15:0];
    idle(g - 2);
    rd(TPC_OFF_CNT);
    chk(nm, {16'h0, 16'(rv[15:0] - a)}, {16'h0, e});
  endtask : gap_chk
  task automatic high_cnt(input int n, input logic [31:0] e, input string nm);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      hi += pout[0];
    end
    chk(nm, 32'(hi), e);
  endtask : high_cnt
  task automatic t_compare();
    wr(TPC_OFF_CTRL, 32'h8);
    wr(TPC_OFF_CH_BASE + TPC_OFF_CH_VAL, 32'h40);
    for (int i = 3; i >= 0; i--) begin
      wr(TPC_OFF_CH_BASE, 32'h14 | 32'(i));
      wr(TPC_OFF_CNT, 32'h0);
      idle(80);
      if (i != 0) chk("cmp_pin", 32'(pout[0]), 32'(i != 2));
      chk("cmp_irq", 32'(irq[0]), 32'h1);
      wr(TPC_OFF_FLAGS, 32'h1);
      idle(4);
      chk("irq_clr", 32'(irq[0]), 32'h0);
    end
  endtask : t_compare
  task automatic t_pwm();
    wr(TPC_OFF_MOD, 32'h8);
    // counter sits above the new modulo and would otherwise run to all-ones
    wr(TPC_OFF_CNT, 32'h0);
    wr(TPC_OFF_CH_BASE + TPC_OFF_CH_VAL, 32'h5);
    wr(TPC_OFF_CH_BASE, 32'ha);
    idle(30);
    // registered pin leaves on the match count, so high spans value plus one
    high_cnt(18, 32'hc, "edge_aligned_pulse_mode_hi");
    wr(TPC_OFF_MOD, 32'h9);
    // value beyond the modulo: no match, so only a capture could set its flag
    wr(TPC_OFF_CH_BASE + TPC_OFF_CH_STEP + TPC_OFF_CH_VAL, 32'h20);
    wr(TPC_OFF_CH_BASE + TPC_OFF_CH_STEP, 32'h11);
    wr(TPC_OFF_CTRL, 32'h28);
    idle(40);
    high_cnt(36, 32'h14, "center_aligned_pulse_mode_hi");
    pm_u.pulse_pin(1);
    idle(8);
    rd(TPC_OFF_FLAGS);
    chk("pwm_flag", 32'(rv[0]), 32'h1);
    chk("center_aligned_pulse_mode_nocap", 32'(rv[1]), 32'h0);
    chk("center_aligned_pulse_mode_oe", 32'(poe[1]), 32'h1);
    for (int k = 0; k < 3; k++) begin
      dbg <= (k == 0);
      stp <= (k == 1);
      wr(TPC_OFF_GATE, (k == 2) ? 32'h2 : 32'h3);
      idle(4);
      gap_chk(22, 16'h0, "held");
    end
    dbg <= 1'b0;
    stp <= 1'b0;
    wr(TPC_OFF_GATE, 32'h3);
  endtask : t_pwm
  task automatic t_count();
    wr(TPC_OFF_CTRL, 32'h48);
    wr(TPC_OFF_FLAGS, 32'h1ff);
    idle(24);
    gap_chk(10, 16'h0, "mod_wrap");
    chk("ovf_irq", 32'(ovf), 32'h1);
    wr(TPC_OFF_CTRL, 32'h108);
    idle(30);
    rd(TPC_OFF_CNT);
    a = rv[15:0];
    idle(7);
    rd(TPC_OFF_CNT);
    chk("updown", {16'h0, 16'(a + rv[15:0])}, 32'h9);
    for (int m = 0; m < 2; m++) begin
      wr(TPC_OFF_MOD, (m == 0) ? 32'h0 : 32'hffff);
      wr(TPC_OFF_CTRL, 32'h8);
      idle(20);
      gap_chk(100, 16'h64, "free_run");
    end
    // window spans whole prescaler and source periods, so counts are exact
    for (int s = 1; s < 4; s++)
      for (int p = 0; p < 8; p++) begin
        wr(TPC_OFF_CTRL, 32'((s << 3) | p));
        idle(40);
        gap_chk(1024, 16'((1024 >> p) >> (s == 1 ? 0 : s)), "rate");
      end
  endtask : t_count
  task automatic t_capture();
    wr(TPC_OFF_CH_BASE, 32'h11);
    wr(TPC_OFF_FLAGS, 32'h1ff);
    wr(TPC_OFF_CTRL, 32'h8);
    dbg <= 1'b1;
    idle(6);
    rd(TPC_OFF_CNT);
    a = rv[15:0];
    pm_u.pulse_pin(0);
    idle(8);
    rd(TPC_OFF_CH_BASE + TPC_OFF_CH_VAL);
    chk("cap_val", {16'h0, rv[15:0]}, {16'h0, a});
    chk("cap_irq", 32'(irq[0]), 32'h1);
    wr(TPC_OFF_FLAGS, 32'h1);
    wr(TPC_OFF_CTRL, 32'h88);
    idle(2);
    pm_u.pulse_pin(0);
    idle(8);
    rd(TPC_OFF_FLAGS);
    chk("pin_cut", 32'(rv[0]), 32'h0);
    pm_u.pulse_cmp();
    idle(8);
    rd(TPC_OFF_FLAGS);
    chk("cmp_cap", 32'(rv[0]), 32'h1);
    wr(TPC_OFF_CH_BASE, 32'h17);
    idle(2);
    chk("route_oe", 32'(poe[0]), 32'h0);
    dbg <= 1'b0;
  endtask : t_capture
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    sys_rst_in = 1'b1;
    req = '0;
    dbg = 1'b0;
    stp = 1'b0;
    tcnt = 2'h0;
    tick = 1'b0;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(TPC_OFF_GATE);
    chk("gate_rst", rv, 32'h3);
    rd(8'hfc);
    chk("unmapped", rv, 32'h0);
    t_compare();
    t_pwm();
    t_count();
    t_capture();
    summarize();
  end
endmodule : tb
